//--- uart_msr_regs.svh
`ifndef UART_STATUS_REGS_SVH
`define UART_STATUS_REGS_SVH

// ----------------------------------------------------------------
// Register offsets on the channel register port
// ----------------------------------------------------------------
`define OFS_DIV_LOW 4'h0
`define OFS_DIV_HIGH 4'h1
`define OFS_ENH_FEAT 4'h2
`define OFS_MODEM_STATUS 4'h6
`define OFS_SCRATCH 4'h7
`define OFS_TX_FREE 4'h8
`define OFS_RX_FILL 4'h9

// ----------------------------------------------------------------
// Register set codes of the select field
// ----------------------------------------------------------------
`define BANK_GENERAL 2'h0
`define BANK_EXTRA_ONE 2'h1
`define BANK_EXTRA_TWO 2'h2
`define BANK_RESERVED 2'h3

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SEL_CNT_EN 0
`define SEL_BANK_LSB 1
`define SEL_BANK_MSB 2
`define ST_CARRIER 7
`define ST_RING 6
`define ST_DSR 5
`define ST_CTS 4
`define CHG_CARRIER 3
`define CHG_RING 2
`define CHG_DSR 1
`define CHG_CTS 0
`define MC_DTR 0
`define MC_RTS 1
`define MC_OUT_ONE 2
`define MC_OUT_TWO 3
`define EF_RX_LSB 0
`define EF_RX_MSB 1
`define EF_TX_LSB 2
`define EF_TX_MSB 3
`define EF_FLOW_TOP 4
`define FLOW_DUAL 2'h3

// ----------------------------------------------------------------
// Reset and idle values
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_FLAGS 4'h0
`define RST_PINS_N 4'hF
`define READ_ZERO 8'h00

`endif

//--- uart_msr_pkg.sv
package uart_status_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [1:0] bank_t;
    typedef logic [3:0] modem_vec_t;
    typedef logic [15:0] divisor_t;
endpackage

//--- modem_input_sync.sv
`include "uart_msr_regs.svh"

module modem_input_sync (
    input wire logic mclk,
    input wire logic rst,
    input wire uart_status_pkg::modem_vec_t pins_n,
    output uart_status_pkg::modem_vec_t levels
);
    uart_status_pkg::modem_vec_t meta_n;
    uart_status_pkg::modem_vec_t sync_n;

    // ----------------------------------------------------------------
    // Two-stage synchroniser, pins idle high
    // ----------------------------------------------------------------
    // First stage feeds only the second stage
    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_n <= `RST_PINS_N;
            sync_n <= `RST_PINS_N;
        end else begin
            meta_n <= pins_n;
            sync_n <= meta_n;
        end
    end

    // Status sense is the complement of the active-low pin
    assign levels = ~sync_n;
endmodule

//--- uart_modem_status_bank_select.sv
`include "uart_msr_regs.svh"

module uart_modem_status_bank_select (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire uart_status_pkg::byte_t cpu_wdata,
    output uart_status_pkg::byte_t cpu_rdata,
    output logic cpu_rdata_valid,
    input wire logic div_access,
    input wire logic loopback,
    input wire logic [3:0] modem_control,
    input wire logic carrier_detect_n,
    input wire logic ring_indicator_n,
    input wire logic dsr_n,
    input wire logic cts_n,
    input wire uart_status_pkg::byte_t tx_free_count,
    input wire uart_status_pkg::byte_t rx_fill_count,
    output logic modem_irq,
    output uart_status_pkg::bank_t extra_bank,
    output logic counters_enabled,
    output uart_status_pkg::divisor_t divisor,
    output logic [1:0] tx_flow_sel,
    output logic [1:0] rx_flow_sel,
    output logic flow_dual_char
);
    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    uart_status_pkg::modem_vec_t pin_levels;
    uart_status_pkg::modem_vec_t levels;
    uart_status_pkg::modem_vec_t prev_levels;
    uart_status_pkg::modem_vec_t change_flags;
    uart_status_pkg::modem_vec_t next_change_flags;
    uart_status_pkg::modem_vec_t change_set;
    logic [2:0] bank_select;
    uart_status_pkg::byte_t scratch_byte;
    uart_status_pkg::byte_t divisor_low;
    uart_status_pkg::byte_t divisor_high;
    uart_status_pkg::byte_t enhanced_features;
    uart_status_pkg::byte_t modem_line_status;
    uart_status_pkg::byte_t next_rdata;
    logic status_read;
    logic general_set;
    logic counters_open;

    // ----------------------------------------------------------------
    // Address decode helper
    // ----------------------------------------------------------------
    // True when the access targets the offset and its set is open
    function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] offset,
                                     input logic set_open);
        reg_hit = (addr == offset) && set_open;
    endfunction

    // ----------------------------------------------------------------
    // Modem input synchroniser
    // ----------------------------------------------------------------
    // Pins enter as {carrier, ring, dsr, cts}
    modem_input_sync modem_input_sync_i (
        .mclk(mclk),
        .rst(rst),
        .pins_n({carrier_detect_n, ring_indicator_n, dsr_n, cts_n}),
        .levels(pin_levels)
    );

    // ----------------------------------------------------------------
    // Status levels, normal or loopback
    // ----------------------------------------------------------------
    // Loopback routes the modem control outputs back into the status bits
    always_comb begin
        if (loopback) begin
            levels[3] = modem_control[`MC_OUT_TWO];
            levels[2] = modem_control[`MC_OUT_ONE];
            levels[1] = modem_control[`MC_DTR];
            levels[0] = modem_control[`MC_RTS];
        end else begin
            levels = pin_levels;
        end
    end

    // ----------------------------------------------------------------
    // Change detection
    // ----------------------------------------------------------------
    // Previous levels for edge detection on synchronised pin values, or on the modem control bits in loopback
    always_ff @(posedge mclk) begin
        if (rst) begin
            prev_levels <= `RST_FLAGS;
        end else begin
            prev_levels <= levels;
        end
    end

    // Ring pin rising is the status level falling
    always_comb begin
        change_set[3] = levels[3] ^ prev_levels[3];
        change_set[2] = prev_levels[2] & ~levels[2];
        change_set[1] = levels[1] ^ prev_levels[1];
        change_set[0] = levels[0] ^ prev_levels[0];
    end

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    assign general_set = (bank_select[`SEL_BANK_MSB:`SEL_BANK_LSB] == `BANK_GENERAL);
    // Set field outranks the counter enable
    assign counters_open = general_set && bank_select[`SEL_CNT_EN];
    assign status_read = cpu_rd && reg_hit(cpu_addr, `OFS_MODEM_STATUS, 1'h1);

    // ----------------------------------------------------------------
    // Change flags
    // ----------------------------------------------------------------
    // A read clears, but a coincident change wins over the clear
    always_comb begin
        if (status_read) begin
            next_change_flags = change_set;
        end else begin
            next_change_flags = change_flags | change_set;
        end
    end

    // Flag flops, zero after reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            change_flags <= `RST_FLAGS;
        end else begin
            change_flags <= next_change_flags;
        end
    end

    // Interrupt raised while any change flag stands
    assign modem_irq = |change_flags;

    // Status image as the host sees it
    assign modem_line_status = {levels, change_flags};

    // ----------------------------------------------------------------
    // Select register, write-only
    // ----------------------------------------------------------------
    // Reserved bits are dropped on write
    always_ff @(posedge mclk) begin
        if (rst) begin
            bank_select <= 3'h0;
        end else if (cpu_wr && reg_hit(cpu_addr, `OFS_MODEM_STATUS, 1'h1)) begin
            bank_select <= cpu_wdata[`SEL_BANK_MSB:`SEL_CNT_EN];
        end
    end

    assign extra_bank = bank_select[`SEL_BANK_MSB:`SEL_BANK_LSB];
    assign counters_enabled = counters_open;

    // ----------------------------------------------------------------
    // Scratch byte
    // ----------------------------------------------------------------
    // Written only while the general set is open
    always_ff @(posedge mclk) begin
        if (rst) begin
            scratch_byte <= `RST_BYTE;
        end else if (cpu_wr && reg_hit(cpu_addr, `OFS_SCRATCH, general_set)) begin
            scratch_byte <= cpu_wdata;
        end
    end

    // ----------------------------------------------------------------
    // Divisor latches
    // ----------------------------------------------------------------
    // Low latch, needs divisor access and the general set
    always_ff @(posedge mclk) begin
        if (rst) begin
            divisor_low <= `RST_BYTE;
        end else if (cpu_wr && div_access && reg_hit(cpu_addr, `OFS_DIV_LOW, general_set)) begin
            divisor_low <= cpu_wdata;
        end
    end

    // High latch, same gating as the low latch
    always_ff @(posedge mclk) begin
        if (rst) begin
            divisor_high <= `RST_BYTE;
        end else if (cpu_wr && div_access && reg_hit(cpu_addr, `OFS_DIV_HIGH, general_set)) begin
            divisor_high <= cpu_wdata;
        end
    end

    // High latch is the upper byte
    assign divisor = {divisor_high, divisor_low};

    // ----------------------------------------------------------------
    // Enhanced feature flow-control field
    // ----------------------------------------------------------------
    // Feature byte lives in the first extra set
    always_ff @(posedge mclk) begin
        if (rst) begin
            enhanced_features <= `RST_BYTE;
        end else if (cpu_wr && reg_hit(cpu_addr, `OFS_ENH_FEAT,
                                       extra_bank == `BANK_EXTRA_ONE)) begin
            enhanced_features <= cpu_wdata;
        end
    end

    // Dual mode pairs the two characters as one sequential word
    assign tx_flow_sel = enhanced_features[`EF_TX_MSB:`EF_TX_LSB];
    assign rx_flow_sel = enhanced_features[`EF_RX_MSB:`EF_RX_LSB];
    assign flow_dual_char = enhanced_features[`EF_FLOW_TOP]
                            && ((tx_flow_sel == `FLOW_DUAL) || (rx_flow_sel == `FLOW_DUAL));

    // ----------------------------------------------------------------
    // Read multiplexer
    // ----------------------------------------------------------------
    // Unmapped or closed offsets read zero
    always_comb begin
        next_rdata = `READ_ZERO;
        if (reg_hit(cpu_addr, `OFS_MODEM_STATUS, 1'h1)) begin
            next_rdata = modem_line_status;
        end else if (reg_hit(cpu_addr, `OFS_SCRATCH, general_set)) begin
            next_rdata = scratch_byte;
        end else if (reg_hit(cpu_addr, `OFS_DIV_LOW, general_set && div_access)) begin
            next_rdata = divisor_low;
        end else if (reg_hit(cpu_addr, `OFS_DIV_HIGH, general_set && div_access)) begin
            next_rdata = divisor_high;
        end else if (reg_hit(cpu_addr, `OFS_ENH_FEAT, extra_bank == `BANK_EXTRA_ONE)) begin
            next_rdata = enhanced_features;
        end else if (reg_hit(cpu_addr, `OFS_TX_FREE, counters_open)) begin
            next_rdata = tx_free_count;
        end else if (reg_hit(cpu_addr, `OFS_RX_FILL, counters_open)) begin
            next_rdata = rx_fill_count;
        end
    end

    // Read data is captured one edge after the read strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            cpu_rdata <= `READ_ZERO;
            cpu_rdata_valid <= 1'b0;
        end else begin
            cpu_rdata_valid <= cpu_rd;
            if (cpu_rd) begin
                cpu_rdata <= next_rdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Properties on the flag, read and latch paths
    sequence status_read_s;
        status_read && (change_set == 4'h0);
    endsequence

    sequence flags_cleared_s;
        change_flags == 4'h0;
    endsequence

    sequence ring_release_s;
        $fell(levels[2]) && !$past(rst);
    endsequence

    sequence counter_read_s;
        cpu_rd && (cpu_addr == `OFS_TX_FREE) && counters_open;
    endsequence

    status_clear_a: assert property (@(posedge mclk) disable iff (rst)
        status_read_s |=> flags_cleared_s)
        else $error("change flags not cleared by status read");

    keep_event_a: assert property (@(posedge mclk) disable iff (rst)
        (status_read && change_set[0]) |=> change_flags[0])
        else $error("change lost during status read");

    irq_level_a: assert property (@(posedge mclk) disable iff (rst)
        (change_set != 4'h0) |=> modem_irq)
        else $error("interrupt not raised by a change");

    ring_edge_a: assert property (@(posedge mclk) disable iff (rst)
        (!change_flags[2] && $rose(levels[2]) && !status_read) |=> !change_flags[2])
        else $error("ring flag set on wrong edge");

    cts_change_a: assert property (@(posedge mclk) disable iff (rst)
        ($changed(levels[0]) && !loopback && $stable(loopback)) |=> change_flags[0])
        else $error("cts change flag missing");

    loop_carrier_a: assert property (@(posedge mclk) disable iff (rst)
        (loopback && cpu_rd && (cpu_addr == `OFS_MODEM_STATUS))
        |=> cpu_rdata[`ST_CARRIER] == $past(modem_control[`MC_OUT_TWO]))
        else $error("loopback carrier bit wrong");

    loop_ring_a: assert property (@(posedge mclk) disable iff (rst)
        loopback |-> modem_line_status[`ST_RING] == modem_control[`MC_OUT_ONE])
        else $error("loopback ring bit wrong");

    loop_dsr_cts_a: assert property (@(posedge mclk) disable iff (rst)
        loopback |-> (modem_line_status[`ST_DSR] == modem_control[`MC_DTR])
                  && (modem_line_status[`ST_CTS] == modem_control[`MC_RTS]))
        else $error("loopback dsr or cts bit wrong");

    counter_gate_a: assert property (@(posedge mclk) disable iff (rst)
        (cpu_rd && ((cpu_addr == `OFS_RX_FILL) || (cpu_addr == `OFS_TX_FREE)) && !counters_open)
        |=> cpu_rdata == 8'h00)
        else $error("level counter read while closed");

    scratch_echo_a: assert property (@(posedge mclk) disable iff (rst)
        (cpu_wr && (cpu_addr == `OFS_SCRATCH) && general_set)
        |=> scratch_byte == $past(cpu_wdata))
        else $error("scratch byte not stored");

    select_write_a: assert property (@(posedge mclk) disable iff (rst)
        (cpu_wr && (cpu_addr == `OFS_MODEM_STATUS))
        |=> extra_bank == $past(cpu_wdata[2:1]))
        else $error("register set select not updated");

    ring_rise_a: assert property (@(posedge mclk) disable iff (rst)
        ring_release_s |=> change_flags[2])
        else $error("ring flag missing on pin rising");

    counter_open_a: assert property (@(posedge mclk) disable iff (rst)
        counter_read_s
        |=> cpu_rdata == $past(tx_free_count))
        else $error("open level counter not returned");

    divisor_store_a: assert property (@(posedge mclk) disable iff (rst)
        (cpu_wr && div_access && general_set && (cpu_addr == `OFS_DIV_HIGH))
        |=> divisor[15:8] == $past(cpu_wdata))
        else $error("divisor high byte not stored");
endmodule

//--- modem_peer.sv
module modem_peer (
    input wire logic mclk,
    input wire logic slow,
    input wire logic [3:0] want_n,
    output logic carrier_detect_n,
    output logic ring_indicator_n,
    output logic dsr_n,
    output logic cts_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] lag1, lag2, lag3;

    // ----------------------------------------------------------------
    // Pin driver
    // ----------------------------------------------------------------
    // Slow mode delays each pin change by three cycles
    always_ff @(posedge mclk) begin
        lag1 <= want_n;
        lag2 <= lag1;
        lag3 <= lag2;
    end

    // Pins follow the request at once or after the delay
    assign {carrier_detect_n, ring_indicator_n, dsr_n, cts_n} = slow ? lag3 : want_n;
endmodule

//--- uart_modem_status_bank_select_bench.sv
module uart_modem_status_bank_select_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk, rst, cpu_wr, cpu_rd, div_access, loopback, slow;
    logic [3:0] cpu_addr, modem_control, want_n;
    uart_status_pkg::byte_t cpu_wdata, cpu_rdata, tx_free_count, rx_fill_count, got, r1;
    logic cpu_rdata_valid, modem_irq, counters_enabled, flow_dual_char;
    logic carrier_detect_n, ring_indicator_n, dsr_n, cts_n;
    uart_status_pkg::bank_t extra_bank;
    uart_status_pkg::divisor_t divisor;
    logic [1:0] tx_flow_sel, rx_flow_sel;
    int n_fail = 0;
    int compares = 0;

    // ----------------------------------------------------------------
    // Design, far side and clock
    // ----------------------------------------------------------------
    uart_modem_status_bank_select uart_modem_status_bank_select_i (
        .mclk(mclk), .rst(rst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
        .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_rdata_valid(cpu_rdata_valid),
        .div_access(div_access), .loopback(loopback), .modem_control(modem_control),
        .carrier_detect_n(carrier_detect_n), .ring_indicator_n(ring_indicator_n),
        .dsr_n(dsr_n), .cts_n(cts_n), .tx_free_count(tx_free_count),
        .rx_fill_count(rx_fill_count), .modem_irq(modem_irq), .extra_bank(extra_bank),
        .counters_enabled(counters_enabled), .divisor(divisor), .tx_flow_sel(tx_flow_sel),
        .rx_flow_sel(rx_flow_sel), .flow_dual_char(flow_dual_char));

    modem_peer modem_peer_i (.mclk(mclk), .slow(slow), .want_n(want_n),
        .carrier_detect_n(carrier_detect_n), .ring_indicator_n(ring_indicator_n),
        .dsr_n(dsr_n), .cts_n(cts_n));

    // Free-running clock
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic summarize();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [3:0] a, input uart_status_pkg::byte_t d);
        @(posedge mclk);
        #1;
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'h1;
        @(posedge mclk);
        #1;
        cpu_wr = 1'h0;
    endtask

    task automatic rd(input logic [3:0] a, output uart_status_pkg::byte_t d);
        @(posedge mclk);
        #1;
        cpu_addr = a;
        cpu_rd = 1'h1;
        @(posedge mclk);
        #1;
        cpu_rd = 1'h0;
        chk(16'(cpu_rdata_valid), 16'h1);
        d = cpu_rdata;
    endtask

    task automatic rdc(input logic [3:0] a, input uart_status_pkg::byte_t e);
        rd(a, got);
        chk(16'(got), 16'(e));
    endtask

    // Change one requested pin level and let it reach the flags
    task automatic pin(input int k, input logic v);
        @(posedge mclk);
        #1;
        want_n[k] = v;
        repeat (8) @(posedge mclk);
        #1;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset();
        rdc(4'h6, 8'h00);
        chk(16'(modem_irq), 16'h0);
        chk(divisor, 16'h0000);
        $display("test reset done");
    endtask

    task automatic test_bank();
        uart_status_pkg::byte_t fv [4] = '{8'h1F, 8'h0F, 8'h15, 8'h1C};
        div_access = 1'h1;
        wr(4'h0, 8'h34);
        wr(4'h1, 8'h12);
        chk(divisor, 16'h1234);
        rdc(4'h1, 8'h12);
        div_access = 1'h0;
        rdc(4'h0, 8'h00);
        wr(4'h0, 8'hFF);
        chk(divisor, 16'h1234);
        wr(4'h7, 8'hA5);
        rdc(4'h7, 8'hA5);
        rdc(4'h8, 8'h00);
        rdc(4'h9, 8'h00);
        wr(4'h6, 8'h01);
        chk(16'(counters_enabled), 16'h1);
        rdc(4'h8, 8'h5A);
        rdc(4'h9, 8'h21);
        rdc(4'h6, 8'h00);
        for (int b = 1; b < 4; b++) begin
            wr(4'h6, 8'(b * 2 + 1));
            chk(16'(extra_bank), 16'(b));
            chk(16'(counters_enabled), 16'h0);
            rdc(4'h8, 8'h00);
            rdc(4'h9, 8'h00);
            rdc(4'h7, 8'h00);
        end
        wr(4'h6, 8'hF8);
        chk({14'h0, extra_bank}, 16'h0);
        chk(16'(counters_enabled), 16'h0);
        rdc(4'h7, 8'hA5);
        wr(4'h6, 8'h02);
        for (int i = 0; i < 4; i++) begin
            wr(4'h2, fv[i]);
            chk({tx_flow_sel, rx_flow_sel, flow_dual_char}, 16'({fv[i][3:0],
                fv[i][4] & (fv[i][3:2] == 2'h3 || fv[i][1:0] == 2'h3)}));
        end
        wr(4'h6, 8'h00);
        $display("test bank done");
    endtask

    task automatic test_pins();
        logic [3:0] fl;
        for (int k = 0; k < 4; k++) begin
            slow = 1'(k % 2);
            pin(k, 1'h0);
            fl = (k == 2) ? 4'h0 : 4'h1 << k;
            chk(16'(modem_irq), 16'(fl != 4'h0));
            rdc(4'h6, {~want_n, fl});
            rdc(4'h6, {~want_n, 4'h0});
            chk(16'(modem_irq), 16'h0);
            pin(k, 1'h1);
            rdc(4'h6, {4'h0, 4'h1 << k});
            rdc(4'h6, 8'h00);
        end
        slow = 1'h0;
        $display("test pins done");
    endtask

    task automatic test_loop();
        loopback = 1'h1;
        rd(4'h6, got);
        for (int j = 0; j < 4; j++) begin
            modem_control = 4'h1 << j;
            repeat (4) @(posedge mclk);
            #1;
            chk(16'(modem_irq), 16'h1);
            rd(4'h6, got);
            chk(16'(got[7:4]), 16'({modem_control[3:2], modem_control[0],
                modem_control[1]}));
        end
        modem_control = 4'h0;
        loopback = 1'h0;
        repeat (4) @(posedge mclk);
        rd(4'h6, got);
        rdc(4'h6, 8'h00);
        $display("test loop done");
    endtask

    task automatic test_race();
        for (int d = 0; d < 6; d++) begin
            @(posedge mclk);
            #1;
            want_n[0] = ~want_n[0];
            repeat (d) @(posedge mclk);
            rd(4'h6, r1);
            repeat (8) @(posedge mclk);
            rd(4'h6, got);
            chk(16'(r1[0] ^ got[0]), 16'h1);
        end
        $display("test race done");
    endtask

    // ----------------------------------------------------------------
    // Main sequence and run limit
    // ----------------------------------------------------------------
    initial begin
        rst = 1'h1;
        cpu_wr = 1'h0;
        cpu_rd = 1'h0;
        cpu_addr = 4'h0;
        cpu_wdata = 8'h00;
        div_access = 1'h0;
        loopback = 1'h0;
        modem_control = 4'h0;
        want_n = 4'hF;
        slow = 1'h0;
        tx_free_count = 8'h5A;
        rx_fill_count = 8'h21;
        repeat (20) @(posedge mclk);
        #1;
        rst = 1'h0;
        test_reset();
        test_bank();
        test_pins();
        test_loop();
        test_race();
        summarize();
    end

    // Cuts a hung run short
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        $display("mismatch at %0t: run limit, got %h expected %h", $time, 1'h0, 1'h1);
        summarize();
    end
endmodule
